//--- pss_params.svh
// Purpose: Offsets, scale figures and timing figures of the supply supervisor
// Assumes: 50 MHz mclk
// Notes:   Long waits are top-level parameters so simulation can shorten them
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

`define PSS_OFS_OT_RESP    8'h0b
`define PSS_OFS_SH_RESP    8'h0d
`define PSS_OFS_REEN_TIME  8'h0e
`define PSS_OFS_BLANK      8'h0f
`define PSS_OFS_TEMP       8'h1a
`define PSS_OFS_TRIM       8'h2b
`define PSS_OFS_PON_SS     8'h2c
`define PSS_OFS_PG         8'h2d
`define PSS_OFS_OT_THR     8'h2f
`define PSS_OFS_SR_SS      8'h54
`define PSS_OFS_SS_FILT    8'h5f

`define PSS_CLK_KHZ        50000
`define PSS_DEB_MS         100
`define PSS_PG_STEP_MS     10
`define PSS_PON_STEP_MS    10
`define PSS_SS_STEP_US     40
`define PSS_SR_STEP_US     4
`define PSS_REEN_STEP_MS   250

`define PSS_OT_STEP_UV     3000
`define PSS_OT_HYST_MV     12
`define PSS_ADC_FS_MV      1580
`define PSS_ADC_CODES      4096
`define PSS_TRIM_UNITY     256
`define PSS_TRIM_SCALE     2
`define PSS_ADC_MAX        12'hfff
`define PSS_LEVEL_MAX      8'hff

`endif

//--- pss_pkg.sv
// Purpose: Types shared by the supply supervisor modules
// Assumes: Nothing beyond the params header
// Notes:   Field layouts match the byte registers bit for bit
package pss_pkg;

	typedef enum logic [1:0] {
		ACT_IGNORE,
		ACT_ORING_OFF,
		ACT_RECT_OFF,
		ACT_SUPPLY_OFF
	} pss_action_t;

	// Bit 7 debounce, bit 6 stay off, bits 5:4 action
	typedef struct packed {
		logic        debounce;
		logic        stay_off;
		pss_action_t action;
		logic [3:0]  unused;
	} pss_flag_cfg_t;

	typedef struct packed {
		logic ac_ok;
		logic oc_primary;
		logic oc_secondary;
		logic ov_local;
		logic ov_load;
		logic uv;
	} pss_health_t;

	typedef enum {
		SEQ_OFF,
		SEQ_DELAY,
		SEQ_RAMP,
		SEQ_ON,
		SEQ_STOP
	} pss_seq_t;

endpackage : pss_pkg

//--- pss_debounce.sv
// Purpose: Holds off a fault until it has stood for a whole interval
// Assumes: cond comes from mclk logic
// Notes:   Any gap restarts the count
`timescale 1ns/1ns
module pss_debounce #(
	parameter int unsigned DEB_CYC = 32'd5000000
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// Condition
	input  wire logic cond,
	input  wire logic use_deb,
	output logic      fault
);
	logic [31:0] cnt_q;

	always_ff @(posedge mclk) begin
		if (reset || !cond) begin
			cnt_q <= 32'h0;
		end else if (cnt_q < DEB_CYC) begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	assign fault = cond && (!use_deb || cnt_q >= DEB_CYC);

endmodule : pss_debounce

//--- pss_ramp.sv
// Purpose: Linear 8-bit ramp, one step every step_cyc cycles
// Assumes: step_cyc is at least one
// Notes:   Without soft fall the level drops to zero at once
`timescale 1ns/1ns
`include "pss_params.svh"
module pss_ramp (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// Control
	input  wire logic        rise,
	input  wire logic        soft_fall,
	input  wire logic [31:0] step_cyc,
	// Level
	output logic [7:0]       level_q,
	output logic             at_top,
	output logic             at_zero
);
	logic [31:0] tick_q;
	logic        tick;

	assign tick    = tick_q + 32'h1 >= step_cyc;
	assign at_top  = level_q == `PSS_LEVEL_MAX;
	assign at_zero = level_q == 8'h00;

	always_ff @(posedge mclk) begin
		if (reset || tick || (rise ? at_top : at_zero)) begin
			tick_q <= 32'h0;
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || (!rise && !soft_fall)) begin
			level_q <= 8'h00;
		end else if (tick && rise && !at_top) begin
			level_q <= level_q + 8'h01;
		end else if (tick && !rise && !at_zero) begin
			level_q <= level_q - 8'h01;
		end
	end

endmodule : pss_ramp

//--- pss_supervisor.sv
// Purpose: Power-on sequencing, power-good outputs and fault supervision
// Assumes: Serial bus engine decodes transfers into the byte register port
// Notes:   Health, fault and ADC inputs are mclk logic; only the request pin is synchronised
`timescale 1ns/1ns
`include "pss_params.svh"
// Behaviour
// - Over-temperature flag sets when corrected reading is below the 8-bit threshold.
// - Threshold rises about 3 mV per step, spanning zero to 765 mV.
// - The flag clears only 12 mV above the threshold.
// - 5-bit trim scales converter gain by roughly plus or minus twelve percent.
// - Primary power-good asserts after delay when healthy; drops after delay on request loss.
// - One bit enables soft-stop ramp down on turn-off by request loss; a flag supply shutdown turns off at once.
// - 2-bit field selects soft-start ramp rise time.
// - 2-bit field selects delay from request to soft-start.
// - 2-bit field selects request source; software bit acts as request.
// - Masking bit chooses all flags or only non-ignored flags for secondary power-good.
// - Polarity bit inverts hardware request pin; inverted means low is on.
// - Rectifier soft-start bit ramps rectifier duty instead of full duty.
// - Always bit repeats rectifier soft-start each enabling, else first only.
// - 2-bit field selects loop low-pass filter bandwidth during soft-start.
// - Blanking bit ignores rectifier conditions until soft-start ramp ends.
// - Reading shows as 12 bits in upper bits of a 16-bit register.
// - Over-temperature response: action field, debounce bit, re-enable or stay-off bit.
// - Share-bus fault response uses the same layout in its own register.
// - 2-bit field selects wait before automatic re-enable after flag shutdown.
// - Blanking bits 0 and 1 ignore the over-temperature and share-bus flags until soft-start ramp completes; bits 2 to 6 do nothing.
module pss_supervisor
	import pss_pkg::*;
#(
	parameter int unsigned DEB_CYC   = `PSS_DEB_MS * `PSS_CLK_KHZ,
	parameter int unsigned PG_STEP   = `PSS_PG_STEP_MS * `PSS_CLK_KHZ,
	parameter int unsigned PON_STEP  = `PSS_PON_STEP_MS * `PSS_CLK_KHZ,
	parameter int unsigned SS_STEP   = `PSS_SS_STEP_US * `PSS_CLK_KHZ / 1000,
	parameter int unsigned SR_STEP   = `PSS_SR_STEP_US * `PSS_CLK_KHZ / 1000,
	parameter int unsigned REEN_STEP = `PSS_REEN_STEP_MS * `PSS_CLK_KHZ
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// Byte register port from the serial management bus engine
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	output logic [15:0]      reg_rdata,
	// Request pin and supply health
	input  wire logic        power_on_request_pin,
	input  wire pss_health_t health,
	input  wire logic        external_flag,
	input  wire logic        share_fault,
	// Temperature converter
	input  wire logic [11:0] temp_sense_input,
	// Rectifier control
	input  wire logic        rect_enable_req,
	input  wire logic        rect_off_cond,
	// Sequencing outputs
	output logic             supply_enable,
	output logic [7:0]       softstart_level,
	output logic             softstart_active,
	output logic [1:0]       softstart_filter_bw,
	output logic             oring_switch_on,
	output logic             sync_rectifier_on,
	output logic [7:0]       sync_rectifier_duty,
	output logic             overtemp_flag,
	output logic             power_good_primary,
	output logic             power_good_secondary
);
	// Registers
	pss_flag_cfg_t ot_resp_q, sh_resp_q;
	logic [7:0]    blank_q, reen_q, trim_q, pon_q, pg_q, thr_q, srss_q, filt_q;
	logic [15:0]   temp_q;
	// Request synchroniser
	logic          pin_s1_q, pin_s2_q;
	// Sequencer
	pss_seq_t      seq_q;
	logic [31:0]   dly_q, pg_cnt_q, reen_cnt_q;
	logic          ramp_rise, ramp_top, ramp_zero;
	// Faults
	logic          ot_q, ot_cond, sh_cond, ot_fault, sh_fault;
	logic [1:0]    lat_q;
	pss_action_t   lat_act [2];
	logic          sw_req, hw_req, req, run_req, healthy, supply_off;
	logic [6:0]    flags, flags_seen, flags_live;
	// Rectifier
	logic          sr_first_q, sr_on_q, sr_go, sr_soft_q;
	logic [7:0]    sr_level;

	// Cycles for a 2-bit time code: code 0 is one step
	function automatic logic [31:0] code_cyc(input logic [1:0] code, input int unsigned step);
		// Widen before the add so code 3 does not wrap to zero
		code_cyc = 32'(step) * ({30'h0, code} + 32'h1);
	endfunction : code_cyc

	// Register writes
	always_ff @(posedge mclk) begin
		if (reset) begin
			ot_resp_q <= '0;
			sh_resp_q <= '0;
			blank_q   <= 8'h00;
			reen_q    <= 8'h00;
			trim_q    <= 8'h00;
			pon_q     <= 8'h00;
			pg_q      <= 8'h00;
			thr_q     <= 8'h00;
			srss_q    <= 8'h00;
			filt_q    <= 8'h00;
		end else if (reg_write) begin
			if (reg_addr == `PSS_OFS_OT_RESP) begin
				ot_resp_q <= pss_flag_cfg_t'(reg_wdata);
			end else if (reg_addr == `PSS_OFS_SH_RESP) begin
				sh_resp_q <= pss_flag_cfg_t'(reg_wdata);
			end else if (reg_addr == `PSS_OFS_REEN_TIME) begin
				reen_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_BLANK) begin
				blank_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_TRIM) begin
				trim_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_PON_SS) begin
				pon_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_PG) begin
				pg_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_OT_THR) begin
				thr_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_SR_SS) begin
				srss_q <= reg_wdata;
			end else if (reg_addr == `PSS_OFS_SS_FILT) begin
				filt_q <= reg_wdata;
			end
		end
	end

	// Register reads; unmapped offsets read zero
	always_comb begin
		reg_rdata = 16'h0000;
		if (reg_addr == `PSS_OFS_OT_RESP) begin
			reg_rdata = {8'h00, ot_resp_q};
		end else if (reg_addr == `PSS_OFS_SH_RESP) begin
			reg_rdata = {8'h00, sh_resp_q};
		end else if (reg_addr == `PSS_OFS_REEN_TIME) begin
			reg_rdata = {8'h00, reen_q};
		end else if (reg_addr == `PSS_OFS_BLANK) begin
			reg_rdata = {8'h00, blank_q};
		end else if (reg_addr == `PSS_OFS_TEMP) begin
			reg_rdata = temp_q;
		end else if (reg_addr == `PSS_OFS_TRIM) begin
			reg_rdata = {8'h00, trim_q};
		end else if (reg_addr == `PSS_OFS_PON_SS) begin
			reg_rdata = {8'h00, pon_q};
		end else if (reg_addr == `PSS_OFS_PG) begin
			reg_rdata = {8'h00, pg_q};
		end else if (reg_addr == `PSS_OFS_OT_THR) begin
			reg_rdata = {8'h00, thr_q};
		end else if (reg_addr == `PSS_OFS_SR_SS) begin
			reg_rdata = {8'h00, srss_q};
		end else if (reg_addr == `PSS_OFS_SS_FILT) begin
			reg_rdata = {8'h00, filt_q};
		end
	end

	// Temperature path: gain trim, then threshold compare with hysteresis
	logic signed [9:0]  gain;
	logic        [23:0] scaled;
	logic        [11:0] corr;
	logic        [31:0] thr_code, clr_code;

	assign gain   = 10'(`PSS_TRIM_UNITY) + 10'(`PSS_TRIM_SCALE) * 10'($signed(trim_q[4:0]));
	assign scaled = {12'h000, temp_sense_input} * {14'h0000, gain};
	assign corr   = |scaled[23:20] ? `PSS_ADC_MAX : scaled[19:8];
	assign thr_code = {24'h0, thr_q} * 32'(`PSS_OT_STEP_UV) * 32'(`PSS_ADC_CODES)
		/ (32'(`PSS_ADC_FS_MV) * 32'd1000);
	assign clr_code = thr_code + 32'(`PSS_OT_HYST_MV) * 32'(`PSS_ADC_CODES) / 32'(`PSS_ADC_FS_MV);

	always_ff @(posedge mclk) begin
		if (reset) begin
			temp_q <= 16'h0000;
		end else begin
			temp_q <= {corr, 4'h0};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ot_q <= 1'b0;
		end else if ({20'h0, corr} < thr_code) begin
			ot_q <= 1'b1;
		end else if ({20'h0, corr} >= clr_code) begin
			ot_q <= 1'b0;
		end
	end
	assign overtemp_flag = ot_q;

	// Request pin crosses in through two flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= power_on_request_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign hw_req = pg_q[0] ? !pin_s2_q : pin_s2_q;
	assign sw_req = pon_q[5];

	always_comb begin
		case (pon_q[7:6])
			2'd0:    req = sw_req;
			2'd1:    req = hw_req;
			2'd2:    req = hw_req && sw_req;
			default: req = hw_req || sw_req;
		endcase
	end

	assign flags_live = flags & ~(softstart_active ? blank_q[6:0] : 7'h00);
	assign flags = {external_flag, !health.ac_ok, health.uv, health.ov_local | health.ov_load,
		health.oc_primary | health.oc_secondary, share_fault, ot_q};
	assign ot_cond = flags_live[0];
	assign sh_cond = flags_live[1];

	pss_debounce #(.DEB_CYC(DEB_CYC)) u_deb_ot (
		.mclk    (mclk),
		.reset   (reset),
		.cond    (ot_cond),
		.use_deb (ot_resp_q.debounce),
		.fault   (ot_fault)
	);
	pss_debounce #(.DEB_CYC(DEB_CYC)) u_deb_sh (
		.mclk    (mclk),
		.reset   (reset),
		.cond    (sh_cond),
		.use_deb (sh_resp_q.debounce),
		.fault   (sh_fault)
	);

	assign lat_act[0] = ot_resp_q.action;
	assign lat_act[1] = sh_resp_q.action;

	// flag shutdown latch; a latch held off by stay-off waits for the request to drop
	always_ff @(posedge mclk) begin
		if (reset) begin
			lat_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0 ? ot_fault : sh_fault) && lat_act[i] != ACT_IGNORE) begin
					lat_q[i] <= 1'b1;
				end else if (!req || (!(i == 0 ? ot_resp_q.stay_off : sh_resp_q.stay_off)
					&& reen_cnt_q >= code_cyc(reen_q[1:0], REEN_STEP))) begin
					lat_q[i] <= 1'b0;
				end
			end
		end
	end

	// re-enable wait, started once the conditions are gone
	always_ff @(posedge mclk) begin
		if (reset || lat_q == 2'b00 || ot_fault || sh_fault) begin
			reen_cnt_q <= 32'h0;
		end else if (reen_cnt_q < code_cyc(reen_q[1:0], REEN_STEP)) begin
			reen_cnt_q <= reen_cnt_q + 32'h1;
		end
	end

	assign supply_off = (lat_q[0] && lat_act[0] == ACT_SUPPLY_OFF) || (lat_q[1] && lat_act[1] == ACT_SUPPLY_OFF);
	assign oring_switch_on = supply_enable && !((lat_q[0] && lat_act[0] == ACT_ORING_OFF)
		|| (lat_q[1] && lat_act[1] == ACT_ORING_OFF));
	assign run_req = req && !supply_off;

	always_ff @(posedge mclk) begin
		if (reset) begin
			seq_q <= SEQ_OFF;
			dly_q <= 32'h0;
		end else begin
			case (seq_q)
				SEQ_OFF: begin
					dly_q <= 32'h0;
					if (run_req) begin
						seq_q <= SEQ_DELAY;
					end
				end
				SEQ_DELAY: begin
					dly_q <= dly_q + 32'h1;
					if (!run_req) begin
						seq_q <= SEQ_OFF;
					end else if (dly_q + 32'h1 >= code_cyc(pon_q[4:3], PON_STEP)) begin
						seq_q <= SEQ_RAMP;
					end
				end
				SEQ_RAMP, SEQ_ON: begin
					if (!run_req) begin
						seq_q <= pon_q[2] && !supply_off ? SEQ_STOP : SEQ_OFF;
					end else if (ramp_top) begin
						seq_q <= SEQ_ON;
					end
				end
				SEQ_STOP: begin
					if (run_req) begin
						seq_q <= SEQ_RAMP;
					end else if (ramp_zero) begin
						seq_q <= SEQ_OFF;
					end
				end
				default: seq_q <= SEQ_OFF;
			endcase
		end
	end

	assign ramp_rise        = seq_q == SEQ_RAMP || seq_q == SEQ_ON;
	assign supply_enable    = seq_q != SEQ_OFF && seq_q != SEQ_DELAY;
	assign softstart_active = seq_q == SEQ_RAMP;
	assign softstart_filter_bw = filt_q[1:0];

	pss_ramp u_ss_ramp (
		.mclk      (mclk),
		.reset     (reset),
		.rise      (ramp_rise),
		.soft_fall (seq_q == SEQ_STOP),
		.step_cyc  (code_cyc(pon_q[1:0], SS_STEP)),
		.level_q   (softstart_level),
		.at_top    (ramp_top),
		.at_zero   (ramp_zero)
	);

	assign healthy = health.ac_ok && !health.oc_primary && !health.oc_secondary
		&& !health.ov_local && !health.ov_load && !health.uv;
	always_ff @(posedge mclk) begin
		if (reset) begin
			pg_cnt_q           <= 32'h0;
			power_good_primary <= 1'b0;
		end else if (!power_good_primary) begin
			pg_cnt_q <= healthy && req ? pg_cnt_q + 32'h1 : 32'h0;
			if (healthy && req && pg_cnt_q >= 32'(PG_STEP) * {28'h0, pg_q[7:4]}) begin
				power_good_primary <= 1'b1;
				pg_cnt_q           <= 32'h0;
			end
		end else if (!healthy) begin
			power_good_primary <= 1'b0;
			pg_cnt_q           <= 32'h0;
		end else begin
			pg_cnt_q <= req ? 32'h0 : pg_cnt_q + 32'h1;
			if (!req && pg_cnt_q >= 32'(PG_STEP) * {28'h0, pg_q[7:4]}) begin
				power_good_primary <= 1'b0;
				pg_cnt_q           <= 32'h0;
			end
		end
	end

	assign flags_seen = pg_q[3] ? (flags & {5'h1f, sh_resp_q.action != ACT_IGNORE,
		ot_resp_q.action != ACT_IGNORE}) : flags;
	always_ff @(posedge mclk) begin
		if (reset) begin
			power_good_secondary <= 1'b0;
		end else begin
			power_good_secondary <= supply_enable && flags_seen == 7'h00;
		end
	end

	assign sr_go = rect_enable_req && supply_enable
		&& !(rect_off_cond && !(blank_q[7] && softstart_active))
		&& !((lat_q[0] && lat_act[0] == ACT_RECT_OFF) || (lat_q[1] && lat_act[1] == ACT_RECT_OFF));

	always_ff @(posedge mclk) begin
		if (reset) begin
			sr_on_q    <= 1'b0;
			sr_first_q <= 1'b0;
			sr_soft_q  <= 1'b0;
		end else begin
			sr_on_q <= sr_go;
			if (sr_go && !sr_on_q) begin
				sr_first_q <= 1'b1;
				sr_soft_q  <= srss_q[0] && (srss_q[1] || !sr_first_q);
			end
		end
	end

	pss_ramp u_sr_ramp (
		.mclk      (mclk),
		.reset     (reset),
		.rise      (sr_on_q),
		.soft_fall (1'b0),
		.step_cyc  (32'(SR_STEP)),
		.level_q   (sr_level),
		.at_top    (),
		.at_zero   ()
	);
	assign sync_rectifier_on   = sr_on_q;
	assign sync_rectifier_duty = !sr_on_q ? 8'h00 : (sr_soft_q ? sr_level : `PSS_LEVEL_MAX);

endmodule : pss_supervisor

//--- pss_supervisor_sva.sv
// Purpose: Port checks for the supply supervisor
// Assumes: One mclk domain, synchronous reset
// Notes:   Bound into every pss_supervisor instance
`timescale 1ns/1ns
module pss_supervisor_chk
	import pss_pkg::*;
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_write,
	input wire logic [15:0] reg_rdata,
	// Status
	input wire pss_health_t health,
	input wire logic        supply_enable,
	input wire logic [7:0]  softstart_level,
	input wire logic        softstart_active,
	input wire logic [1:0]  softstart_filter_bw,
	input wire logic        sync_rectifier_on,
	input wire logic [7:0]  sync_rectifier_duty,
	input wire logic        overtemp_flag,
	input wire logic        power_good_primary,
	input wire logic        power_good_secondary
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	logic [7:0] wdata_q;

	always_ff @(posedge mclk) begin
		wdata_q <= reg_wdata;
	end

	wr_readback_a: assert property ((reg_write && reg_addr == 8'h2c) ##1 (reg_addr == 8'h2c)
		|-> reg_rdata == {8'h00, wdata_q}) else $error("control byte readback wrong");
	bw_follow_a: assert property (reg_write && reg_addr == 8'h5f |=> softstart_filter_bw == wdata_q[1:0])
		else $error("filter select not applied");
	temp_low_zero_a: assert property (reg_addr == 8'h1a |-> reg_rdata[3:0] == 4'h0)
		else $error("reading low nibble not zero");
	duty_off_zero_a: assert property (!sync_rectifier_on |-> sync_rectifier_duty == 8'h00)
		else $error("rectifier duty while off");
	ramp_rising_a: assert property (softstart_active && $past(softstart_active)
		|-> softstart_level >= $past(softstart_level)) else $error("soft-start level fell");
	ramp_in_supply_a: assert property (softstart_active |-> supply_enable)
		else $error("ramp without supply");
	pg1_unhealthy_a: assert property (!health.ac_ok || health.uv |=> !power_good_primary)
		else $error("primary good while unhealthy");
	pg2_supply_a: assert property (!supply_enable |=> !power_good_secondary)
		else $error("secondary good with supply off");

	cover property ($rose(supply_enable));
	cover property ($rose(power_good_primary));
	cover property ($rose(overtemp_flag));
	cover property ($rose(power_good_secondary));
endmodule : pss_supervisor_chk

bind pss_supervisor pss_supervisor_chk chk_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_rdata,
	.health, .supply_enable, .softstart_level, .softstart_active, .softstart_filter_bw,
	.sync_rectifier_on, .sync_rectifier_duty, .overtemp_flag, .power_good_primary, .power_good_secondary);

//--- pss_host.sv
// Purpose: Host side of the byte register port
// Assumes: Bench calls tasks only after reset release
// Notes:   Drives at the falling edge
`timescale 1ns/1ns
module pss_host (
	// Clock
	input  wire logic        mclk,
	// Register port
	output logic [7:0]       reg_addr,
	output logic [7:0]       reg_wdata,
	output logic             reg_write,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge mclk);
		reg_write = 1'b0;
		// Stale data would hide a late capture
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		@(posedge mclk);
		d = reg_rdata;
	endtask : rd
endmodule : pss_host

//--- tb_power_supply_supervisor.sv
// Purpose: Self-checking bench for the supply supervisor
// Assumes: Shortened wait parameters
// Notes:   Temperature expectations come from the integer model below
`timescale 1ns/1ns
module tb_power_supply_supervisor
	import pss_pkg::*;
;
	localparam int PON = 4;
	localparam int SS = 1;
	logic        mclk, reset, reg_write, power_on_request_pin, external_flag, share_fault;
	logic [7:0]  reg_addr, reg_wdata, softstart_level, sync_rectifier_duty, v;
	logic [15:0] reg_rdata, rv;
	logic [11:0] temp_sense_input;
	logic [1:0]  softstart_filter_bw;
	pss_health_t health;
	logic        rect_enable_req, rect_off_cond, supply_enable, softstart_active, oring_switch_on;
	logic        sync_rectifier_on, overtemp_flag, power_good_primary, power_good_secondary;
	int          error_cnt, check_count, t0, r0, t1, r1, n, code, trim;
	logic [7:0]  regs [8] = '{8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h2b, 8'h2f, 8'h54, 8'h5f};
	int          offs [5] = '{-1, 30, 31, 0, -1};
	logic        exp_ot [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	pss_supervisor #(.DEB_CYC(8), .PG_STEP(4), .PON_STEP(PON), .SS_STEP(SS), .SR_STEP(1), .REEN_STEP(8)) dut_u (.*);
	pss_host host_u (.*);

	always #10 mclk = ~mclk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		if (error_cnt == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	function automatic logic sig(input int k);
		case (k)
			0: return supply_enable;
			1: return softstart_active;
			2: return power_good_primary;
			default: return power_good_secondary;
		endcase
	endfunction : sig

	// Bounded wait; running out is a mismatch
	task automatic wait_lvl(input int k, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		check_count++;
		while (sig(k) !== lvl) begin
			@(negedge mclk);
			cnt++;
			if (cnt > lim) begin
				error_cnt++;
				tally_and_finish();
			end
		end
	endtask : wait_lvl

	function automatic int corr(input int raw, input int tr);
		int t;
		t = tr > 15 ? tr - 32 : tr;
		t = raw * (256 + 2 * t) / 256;
		return t > 4095 ? 4095 : t;
	endfunction : corr

	task automatic seq(input logic [7:0] ctl, output int t_on, output int t_ramp);
		host_u.wr(8'h2c, 8'h00);
		wait_lvl(0, 1'b0, 50, t_on);
		host_u.wr(8'h2c, ctl);
		wait_lvl(0, 1'b1, 300, t_on);
		wait_lvl(1, 1'b0, 2000, t_ramp);
		check({8'h00, softstart_level}, 16'h00ff);
	endtask : seq

	initial begin
		{mclk, reset, power_on_request_pin, external_flag, share_fault} = 5'b01000;
		{rect_enable_req, rect_off_cond} = 2'b00;
		health = 6'b000000;
		temp_sense_input = 12'hfff;
		void'($urandom(41));
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		health = 6'b100000;
		foreach (regs[i]) begin
			v = 8'($urandom);
			host_u.wr(regs[i], v);
			host_u.rd(regs[i], rv);
			check(rv, {8'h00, v});
			host_u.wr(regs[i], 8'h00);
		end
		host_u.rd(8'h30, rv);
		check(rv, 16'h0000);
		host_u.wr(8'h1a, 8'h55);
		for (int i = 0; i < 4; i++) begin
			trim = int'($urandom_range(31, 0));
			host_u.wr(8'h2b, 8'(trim));
			temp_sense_input = 12'($urandom);
			repeat (2) @(negedge mclk);
			host_u.rd(8'h1a, rv);
			check(rv, {12'(corr(int'(temp_sense_input), trim)), 4'h0});
		end
		host_u.wr(8'h2b, 8'h00);
		v = 8'($urandom_range(255, 16));
		code = int'(longint'(v) * 3000 * 4096 / 1580000);
		host_u.wr(8'h2f, v);
		foreach (offs[i]) begin
			temp_sense_input = 12'(code + offs[i]);
			repeat (3) @(negedge mclk);
			check({15'h0, overtemp_flag}, {15'h0, exp_ot[i]});
		end
		temp_sense_input = 12'hfff;
		host_u.wr(8'h2f, 8'h00);
		seq(8'h20, t0, r0);
		seq(8'h38, t1, r1);
		check(16'(t1 - t0), 16'(3 * PON));
		seq(8'h25, t1, r1);
		check(16'(r1 - r0), 16'(255 * SS));
		host_u.wr(8'h2c, 8'h04);
		repeat (4) @(negedge mclk);
		check({15'h0, supply_enable}, 16'h0001);
		wait_lvl(0, 1'b0, 2000, n);
		check({8'h00, softstart_level}, 16'h0000);
		host_u.wr(8'h2d, 8'h20);
		host_u.wr(8'h2c, 8'h20);
		wait_lvl(2, 1'b1, 100, n);
		check(16'(n >= 6), 16'h0001);
		wait_lvl(3, 1'b1, 300, n);
		share_fault = 1'b1;
		repeat (3) @(negedge mclk);
		check({15'h0, power_good_secondary}, 16'h0000);
		host_u.wr(8'h2d, 8'h28);
		repeat (3) @(negedge mclk);
		check({15'h0, power_good_secondary}, 16'h0001);
		share_fault = 1'b0;
		host_u.wr(8'h2c, 8'h00);
		repeat (3) @(negedge mclk);
		check({15'h0, power_good_primary}, 16'h0001);
		wait_lvl(2, 1'b0, 50, n);
		host_u.wr(8'h0d, 8'hf0);
		host_u.wr(8'h2c, 8'h20);
		wait_lvl(0, 1'b1, 300, n);
		repeat (2) begin
			share_fault = 1'b1;
			repeat (6) @(negedge mclk);
			share_fault = 1'b0;
			@(negedge mclk);
		end
		check({15'h0, supply_enable}, 16'h0001);
		share_fault = 1'b1;
		repeat (14) @(negedge mclk);
		check({15'h0, supply_enable}, 16'h0000);
		share_fault = 1'b0;
		repeat (20) @(negedge mclk);
		check({15'h0, supply_enable}, 16'h0000);
		host_u.wr(8'h2c, 8'h00);
		host_u.wr(8'h0d, 8'h00);
		host_u.wr(8'h0f, 8'h80);
		host_u.wr(8'h54, 8'h01);
		{rect_enable_req, rect_off_cond} = 2'b11;
		host_u.wr(8'h2c, 8'h20);
		wait_lvl(0, 1'b1, 300, n);
		repeat (3) @(negedge mclk);
		check({8'h00, sync_rectifier_duty}, 16'h0002);
		check({15'h0, oring_switch_on}, 16'h0001);
		wait_lvl(1, 1'b0, 2000, n);
		repeat (2) @(negedge mclk);
		check({15'h0, sync_rectifier_on}, 16'h0000);
		rect_off_cond = 1'b0;
		repeat (3) @(negedge mclk);
		check({8'h00, sync_rectifier_duty}, 16'h00ff);
		host_u.wr(8'h54, 8'h03);
		rect_enable_req = 1'b0;
		repeat (2) @(negedge mclk);
		rect_enable_req = 1'b1;
		repeat (3) @(negedge mclk);
		check({8'h00, sync_rectifier_duty}, 16'h0002);
		rect_enable_req = 1'b0;
		host_u.wr(8'h0d, 8'h30);
		share_fault = 1'b1;
		repeat (3) @(negedge mclk);
		share_fault = 1'b0;
		check({15'h0, supply_enable}, 16'h0000);
		wait_lvl(0, 1'b1, 300, n);
		check(16'(n >= 8), 16'h0001);
		host_u.wr(8'h0d, 8'h00);
		host_u.wr(8'h0f, 8'h00);
		host_u.wr(8'h2c, 8'h00);
		host_u.wr(8'h2d, 8'h01);
		host_u.wr(8'h2c, 8'h40);
		wait_lvl(0, 1'b1, 300, n);
		power_on_request_pin = 1'b1;
		wait_lvl(0, 1'b0, 50, n);
		host_u.wr(8'h2d, 8'h00);
		wait_lvl(0, 1'b1, 300, n);
		host_u.wr(8'h2c, 8'h80);
		wait_lvl(0, 1'b0, 50, n);
		host_u.wr(8'h2c, 8'hc0);
		wait_lvl(0, 1'b1, 300, n);
		tally_and_finish();
	end
endmodule : tb_power_supply_supervisor
